// ---- hw/osel_consts.vh ----
`ifndef OSEL_CONSTS_VH
`define OSEL_CONSTS_VH

// ----------------------------------------------------------------------
// Register indices on the plain register port.
// ----------------------------------------------------------------------
`define OSEL_ADDR_W 2
`define OSEL_A_OSC_CTRL 2'h0
`define OSEL_A_CLK_DIV 2'h1
`define OSEL_A_RC_TUNE 2'h2

// ----------------------------------------------------------------------
// Oscillator control field positions.
// ----------------------------------------------------------------------
`define OSEL_CUR_HI 14
`define OSEL_CUR_LO 12
`define OSEL_NEW_HI 10
`define OSEL_NEW_LO 8
`define OSEL_LOCK_BIT 7
`define OSEL_PLL_BIT 5
`define OSEL_FAIL_BIT 3
`define OSEL_SECONDARY_OSC_BIT 1
`define OSEL_SWREQ_BIT 0

// ----------------------------------------------------------------------
// Clock divider field positions and reset value.
// ----------------------------------------------------------------------
`define OSEL_ROI_BIT 15
`define OSEL_DOZE_HI 14
`define OSEL_DOZE_LO 12
`define OSEL_DOZEN_BIT 11
`define OSEL_RCDIV_HI 10
`define OSEL_RCDIV_LO 8
`define OSEL_DIV_RST 16'h3000
`define OSEL_DIV_MASK 16'hff00

// ----------------------------------------------------------------------
// Source encodings shared by the current and new source fields.
// ----------------------------------------------------------------------
`define OSEL_SRC_FRC 3'h0
`define OSEL_SRC_FRC_PLL 3'h1
`define OSEL_SRC_PRI 3'h2
`define OSEL_SRC_PRI_PLL 3'h3
`define OSEL_SRC_SEC 3'h4
`define OSEL_SRC_LOW_POWER_RC 3'h5
`define OSEL_SRC_LPFRC_DIV 3'h6
`define OSEL_SRC_FRC_DIV 3'h7

// ----------------------------------------------------------------------
// Primary mode encodings and switching configuration.
// ----------------------------------------------------------------------
`define OSEL_PM_EXT 2'h0
`define OSEL_PM_MED 2'h1
`define OSEL_PM_HS 2'h2
`define OSEL_PM_OFF 2'h3
`define OSEL_SWDIS_BIT 1
`define OSEL_MON_ON 2'h0

// ----------------------------------------------------------------------
// Timing and widths.
// ----------------------------------------------------------------------
`define OSEL_SWITCH_CYC 16
`define OSEL_TUNE_W 6
`define OSEL_TUNE_RST 6'h00

`endif

// ---- hw/osel_sync.v ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Two-stage synchroniser for levels from outside the clock domain.
// ----------------------------------------------------------------------
module osel_sync #(
   parameter WIDTH = 1
) (
   input wire clk_sys,
   input wire srst,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // The first stage is read only by the second stage.
   always @(posedge clk_sys) begin
      if (srst) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // osel_sync

// ---- hw/osel_top.v ----
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "osel_consts.vh"

// Contract
// - Reset picks source from two config fields.
// - Erased config starts fast RC with postscaler.
// - Range field declares external clock frequency.
// - Switching allowed only when upper bit zero.
// - Fail-safe monitor enabled only at 00.
// - Internal mode selects among internal RC sources.
// - Mode 00 with 100 gives secondary.
// - 011 selects primary through the PLL.
// - 010 selects primary without the PLL.
// - Pin function config bit for internal modes.
// - Current source read-only at bits 14-12.
// - New source resets from initial config.
// - New source encoding matches current encoding.
// - PLL lock zero during switch, non-PLL.
// - Lock bit is set-only by software.
// - Fail flag hardware-set, software clear-only.
// - Unimplemented bits read zero, ignore writes.
// - Tuning register steps fast RC frequency.
// - Divider register sets doze and postscaler.
// - Switch request cleared when switch completes.
// - Monitor on and locked refuses changes.
// - Detected clock failure sets fail flag.
module osel_top #(
   parameter SWITCH_CYC = `OSEL_SWITCH_CYC,
   parameter TUNE_W = `OSEL_TUNE_W
) (
   input wire clk_sys,
   input wire srst,
   input wire [1:0] primary_mode_cfg,
   input wire [2:0] initial_source_cfg,
   input wire [1:0] ext_clock_range_cfg,
   input wire [1:0] switch_monitor_cfg,
   input wire osc_pin_function_cfg,
   input wire pll_locked_in,
   input wire clock_fail_in,
   input wire [`OSEL_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output reg [2:0] active_source,
   output reg [1:0] primary_kind,
   output reg primary_osc_en,
   output reg secondary_osc_en,
   output reg fast_rc_en,
   output reg low_power_fast_rc_en,
   output reg low_power_rc_en,
   output reg pll_en,
   output reg postscaler_en,
   output reg [2:0] postscaler_sel,
   output reg [1:0] ext_range,
   output reg osc_pin_gpio,
   output reg fail_monitor_en,
   output reg switch_busy,
   output reg doze_en,
   output reg [2:0] doze_ratio,
   output reg doze_exit_on_irq,
   output reg [TUNE_W-1:0] rc_tune
);

   // -------------------------------------------------------------------
   // Local definitions.
   // -------------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_SWITCH = 1'b1;
   localparam CNT_W = 16;
   localparam [31:0] SWITCH_CYC_W = SWITCH_CYC;
   // The switch time is cut to the counter width on purpose.
   localparam [CNT_W-1:0] CNT_LAST = SWITCH_CYC_W[CNT_W-1:0] - 16'h0001;

   // Tells whether a source encoding runs through the PLL.
   function is_pll_src;
      input [2:0] src;
      begin
         is_pll_src = (src == `OSEL_SRC_PRI_PLL) || (src == `OSEL_SRC_FRC_PLL);
      end
   endfunction

   // Tells whether a source encoding uses the primary oscillator.
   function is_pri_src;
      input [2:0] src;
      begin
         is_pri_src = (src == `OSEL_SRC_PRI_PLL) || (src == `OSEL_SRC_PRI);
      end
   endfunction

   // -------------------------------------------------------------------
   // Configuration captured at reset.
   // -------------------------------------------------------------------
   reg [1:0] pmode_q;
   reg [1:0] range_q;
   reg [1:0] swmon_q;
   reg pinfn_q;

   // Config fields are sampled while reset is held so that a later
   // change on those inputs cannot disturb the running clock plan.
   always @(posedge clk_sys) begin
      if (srst) begin
         pmode_q <= primary_mode_cfg;
         range_q <= ext_clock_range_cfg;
         swmon_q <= switch_monitor_cfg;
         pinfn_q <= osc_pin_function_cfg;
      end
   end

   wire switch_ok = ~swmon_q[`OSEL_SWDIS_BIT];
   wire mon_on = (swmon_q == `OSEL_MON_ON);

   // -------------------------------------------------------------------
   // Synchronised pin levels.
   // -------------------------------------------------------------------
   wire [1:0] pins_s;

   osel_sync #(
      .WIDTH(2)
   ) u_sync (
      .clk_sys(clk_sys),
      .srst(srst),
      .async_in({clock_fail_in, pll_locked_in}),
      .sync_out(pins_s)
   );

   wire pll_lock_s = pins_s[0];
   wire fail_s = pins_s[1];
   reg fail_prev_q;

   // Edge memory for the failure level, fed only from the second stage.
   always @(posedge clk_sys) begin
      if (srst) begin
         fail_prev_q <= 1'b0;
      end else begin
         fail_prev_q <= fail_s;
      end
   end

   wire fail_evt = mon_on & fail_s & ~fail_prev_q;

   // -------------------------------------------------------------------
   // Oscillator control state.
   // -------------------------------------------------------------------
   reg [2:0] cur_q;
   reg [2:0] new_q;
   reg [2:0] tgt_q;
   reg lock_q;
   reg fail_q;
   reg secondary_osc_q;
   reg swreq_q;
   reg st_q;
   reg [CNT_W-1:0] cnt_q;

   wire wr_osc = reg_wr && (reg_addr == `OSEL_A_OSC_CTRL);
   wire locked = mon_on & lock_q;
   // A request written while the sequencer clears the bit wins, so none is lost.
   wire sw_set = wr_osc && reg_wdata[`OSEL_SWREQ_BIT] && switch_ok && !locked;
   wire in_switch = (st_q == ST_SWITCH);
   wire pll_stat = pll_lock_s & is_pll_src(cur_q) & ~in_switch;

   // Register writes, the switch sequence and the hardware flags share
   // one process so that every bit has a single writer.
   always @(posedge clk_sys) begin
      if (srst) begin
         cur_q <= initial_source_cfg;
         new_q <= initial_source_cfg;
         tgt_q <= initial_source_cfg;
         lock_q <= 1'b0;
         fail_q <= 1'b0;
         secondary_osc_q <= 1'b0;
         swreq_q <= 1'b0;
         st_q <= ST_IDLE;
         cnt_q <= {CNT_W{1'b0}};
      end else begin
         // Software side of the control register.
         if (wr_osc) begin
            if (!locked) begin
               new_q <= reg_wdata[`OSEL_NEW_HI:`OSEL_NEW_LO];
            end
            if (reg_wdata[`OSEL_LOCK_BIT]) begin
               lock_q <= 1'b1;
            end
            if (!reg_wdata[`OSEL_FAIL_BIT]) begin
               fail_q <= 1'b0;
            end
            secondary_osc_q <= reg_wdata[`OSEL_SECONDARY_OSC_BIT];
            // A refused request never shows in the request bit.
            if (sw_set) begin
               swreq_q <= 1'b1;
            end
         end
         // A failure in the same cycle as a clearing write still lands.
         if (fail_evt) begin
            fail_q <= 1'b1;
         end
         // Switch sequencer; without switching rights it stays idle,
         // so the power-on source is kept for good.
         case (st_q)
            ST_IDLE: begin
               if (swreq_q && switch_ok) begin
                  if (new_q == cur_q) begin
                     swreq_q <= sw_set;
                  end else begin
                     tgt_q <= new_q;
                     cnt_q <= {CNT_W{1'b0}};
                     st_q <= ST_SWITCH;
                  end
               end
            end
            ST_SWITCH: begin
               if (cnt_q == CNT_LAST) begin
                  cur_q <= tgt_q;
                  swreq_q <= sw_set;
                  st_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h0001;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Clock divider and tuning registers.
   // -------------------------------------------------------------------
   reg [15:0] div_q;
   reg [TUNE_W-1:0] tune_q;

   // The low byte of the divider is unimplemented and never stored.
   always @(posedge clk_sys) begin
      if (srst) begin
         div_q <= `OSEL_DIV_RST;
         tune_q <= `OSEL_TUNE_RST;
      end else if (reg_wr) begin
         if (reg_addr == `OSEL_A_CLK_DIV) begin
            div_q <= reg_wdata & `OSEL_DIV_MASK;
         end
         if (reg_addr == `OSEL_A_RC_TUNE) begin
            tune_q <= reg_wdata[TUNE_W-1:0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Read path.
   // -------------------------------------------------------------------
   reg [15:0] rd_d;

   // Unmapped indices and unimplemented bits read as zero.
   always @* begin
      rd_d = 16'h0000;
      case (reg_addr)
         `OSEL_A_OSC_CTRL: begin
            rd_d[`OSEL_CUR_HI:`OSEL_CUR_LO] = cur_q;
            rd_d[`OSEL_NEW_HI:`OSEL_NEW_LO] = new_q;
            rd_d[`OSEL_LOCK_BIT] = lock_q;
            rd_d[`OSEL_PLL_BIT] = pll_stat;
            rd_d[`OSEL_FAIL_BIT] = fail_q;
            rd_d[`OSEL_SECONDARY_OSC_BIT] = secondary_osc_q;
            rd_d[`OSEL_SWREQ_BIT] = swreq_q;
         end
         `OSEL_A_CLK_DIV: begin
            rd_d = div_q;
         end
         `OSEL_A_RC_TUNE: begin
            rd_d[TUNE_W-1:0] = tune_q;
         end
         default: begin
            rd_d = 16'h0000;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe.
   always @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= rd_d;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // -------------------------------------------------------------------
   // Oscillator steering decoded from the active source.
   // -------------------------------------------------------------------
   reg [1:0] kind_d;
   reg pri_d;
   reg frc_d;
   reg lpfrc_d;
   reg low_power_rc_d;
   reg psc_d;
   reg gpio_d;

   // Primary mode picks the crystal kind; internal and secondary modes
   // leave the second oscillator pin to its own config bit.
   always @* begin
      kind_d = pmode_q;
      pri_d = is_pri_src(cur_q) && (pmode_q != `OSEL_PM_OFF);
      frc_d = 1'b0;
      lpfrc_d = 1'b0;
      low_power_rc_d = 1'b0;
      psc_d = 1'b0;
      gpio_d = 1'b0;
      case (cur_q)
         `OSEL_SRC_FRC_DIV: begin
            frc_d = 1'b1;
            psc_d = 1'b1;
         end
         `OSEL_SRC_LPFRC_DIV: begin
            lpfrc_d = 1'b1;
            psc_d = 1'b1;
         end
         `OSEL_SRC_LOW_POWER_RC: begin
            low_power_rc_d = 1'b1;
         end
         `OSEL_SRC_FRC_PLL: begin
            frc_d = 1'b1;
            psc_d = 1'b1;
         end
         `OSEL_SRC_FRC: begin
            frc_d = 1'b1;
         end
         default: begin
            frc_d = 1'b0;
         end
      endcase
      // The pin is free when no primary crystal or clock owns it.
      if (!pri_d) begin
         gpio_d = pinfn_q;
      end
   end

   // Every steering output is registered.
   always @(posedge clk_sys) begin
      if (srst) begin
         active_source <= `OSEL_SRC_FRC_DIV;
         primary_kind <= `OSEL_PM_OFF;
         primary_osc_en <= 1'b0;
         secondary_osc_en <= 1'b0;
         fast_rc_en <= 1'b0;
         low_power_fast_rc_en <= 1'b0;
         low_power_rc_en <= 1'b0;
         pll_en <= 1'b0;
         postscaler_en <= 1'b0;
         postscaler_sel <= 3'h0;
         ext_range <= 2'h3;
         osc_pin_gpio <= 1'b0;
         fail_monitor_en <= 1'b0;
         switch_busy <= 1'b0;
         doze_en <= 1'b0;
         doze_ratio <= 3'h0;
         doze_exit_on_irq <= 1'b0;
         rc_tune <= `OSEL_TUNE_RST;
      end else begin
         active_source <= cur_q;
         primary_kind <= kind_d;
         primary_osc_en <= pri_d;
         // Secondary runs when selected or kept on by software.
         secondary_osc_en <= secondary_osc_q | (cur_q == `OSEL_SRC_SEC);
         fast_rc_en <= frc_d;
         low_power_fast_rc_en <= lpfrc_d;
         low_power_rc_en <= low_power_rc_d;
         pll_en <= is_pll_src(cur_q);
         postscaler_en <= psc_d;
         postscaler_sel <= div_q[`OSEL_RCDIV_HI:`OSEL_RCDIV_LO];
         ext_range <= range_q;
         osc_pin_gpio <= gpio_d;
         fail_monitor_en <= mon_on;
         switch_busy <= in_switch;
         doze_en <= div_q[`OSEL_DOZEN_BIT];
         doze_ratio <= div_q[`OSEL_DOZE_HI:`OSEL_DOZE_LO];
         doze_exit_on_irq <= div_q[`OSEL_ROI_BIT];
         rc_tune <= tune_q;
      end
   end

endmodule // osel_top

// ---- dv/osel_top_props.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Port-level checks on the source selector.
// ----------------------------------------------------------------------
module osel_top_chk #(
   parameter SWITCH_CYC = 16
) (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [1:0] switch_monitor_cfg,
   input wire logic [1:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic [2:0] active_source,
   input wire logic [1:0] primary_kind,
   input wire logic primary_osc_en,
   input wire logic pll_en,
   input wire logic postscaler_en,
   input wire logic osc_pin_gpio,
   input wire logic fail_monitor_en,
   input wire logic switch_busy
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // Read data stand for one cycle only, so a stale word cannot be mistaken for fresh.
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   unimpl_zero_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0
      |-> (reg_rdata & 16'h8854) == 16'h0000) else $error("unused control bit set");
   cur_field_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0
      |-> reg_rdata[14:12] == active_source) else $error("current field differs");
   pll_status_a: assert property ($past(reg_rd) && $past(reg_addr) == 2'h0 && reg_rdata[5]
      |-> pll_en && !switch_busy) else $error("pll status while unused");
   monitor_cfg_a: assert property (!$past(srst) |->
      fail_monitor_en == (switch_monitor_cfg == 2'h0))
      else $error("monitor enable wrong");
   switch_ends_a: assert property ($rose(switch_busy) |-> ##[1:40] !switch_busy)
      else $error("switch never completes");
   switch_off_a: assert property (switch_monitor_cfg[1] && !$past(srst) && !$past(srst, 2)
      |-> $stable(active_source) && !switch_busy) else $error("switch while disabled");
   pll_use_a: assert property (pll_en == (active_source == 3'h3 || active_source == 3'h1))
      else $error("pll use wrong");
   post_use_a: assert property (!$past(srst) |->
      postscaler_en == (active_source inside {3'h7, 3'h6, 3'h1}))
      else $error("postscaler use wrong");
   prim_use_a: assert property (primary_osc_en == (active_source[2:1] == 2'h1
      && primary_kind != 2'h3)) else $error("primary use wrong");
   pin_func_a: assert property (osc_pin_gpio |-> !primary_osc_en)
      else $error("pin taken from primary");
endmodule // osel_top_chk

bind osel_top osel_top_chk #(.SWITCH_CYC(SWITCH_CYC)) u_chk (.clk_sys(clk_sys), .srst(srst),
   .switch_monitor_cfg(switch_monitor_cfg), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .active_source(active_source), .primary_kind(primary_kind),
   .primary_osc_en(primary_osc_en), .pll_en(pll_en), .postscaler_en(postscaler_en),
   .osc_pin_gpio(osc_pin_gpio), .fail_monitor_en(fail_monitor_en), .switch_busy(switch_busy));

// ---- dv/osel_osc_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Oscillator side: PLL lock after settling, monitor failure level.
// ----------------------------------------------------------------------
module osel_osc_model (
   input wire logic clk_sys,
   input wire logic pll_en,
   input wire logic fail_cmd,
   output logic pll_locked_in,
   output logic clock_fail_in
);
   logic [2:0] settle_q;

   initial begin
      settle_q = 3'h0;
      pll_locked_in = 1'b0;
      clock_fail_in = 1'b0;
   end

   // Lock only after a settling time, so a design that trusts lock too early shows it.
   always @(posedge clk_sys) begin
      if (!pll_en) begin
         settle_q <= 3'h0;
      end else if (settle_q != 3'h7) begin
         settle_q <= settle_q + 3'h1;
      end
      pll_locked_in <= pll_en && (settle_q == 3'h7);
      clock_fail_in <= fail_cmd;
   end
endmodule // osel_osc_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic [1:0] primary_mode_cfg = 2'h3;
   logic [2:0] initial_source_cfg = 3'h7;
   logic [1:0] ext_clock_range_cfg = 2'h3;
   logic [1:0] switch_monitor_cfg = 2'h3;
   logic osc_pin_function_cfg = 1'b1;
   logic [1:0] reg_addr = 2'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic fail_cmd = 1'b0;
   wire pll_locked_in, clock_fail_in, primary_osc_en, secondary_osc_en, pll_en, postscaler_en;
   wire osc_pin_gpio, fail_monitor_en;
   wire fast_rc_en, low_power_fast_rc_en, low_power_rc_en, doze_en, doze_exit_on_irq, switch_busy;
   wire [2:0] postscaler_sel, doze_ratio;
   wire [1:0] primary_kind;
   wire [5:0] rc_tune;
   wire [15:0] reg_rdata;
   wire [2:0] active_source;
   wire [1:0] ext_range;
   int n_errors = 0;
   int comparisons = 0;

   // ----------------------------------------------------------------------
   // Clock, partner and design.
   // ----------------------------------------------------------------------
   initial forever #10 clk_sys = ~clk_sys;

   osel_osc_model u_osc (.clk_sys(clk_sys), .pll_en(pll_en), .fail_cmd(fail_cmd),
      .pll_locked_in(pll_locked_in), .clock_fail_in(clock_fail_in));

   // A short switch time keeps the run brief; every wait below is bounded well above it.
   osel_top #(.SWITCH_CYC(2)) u_dut (.clk_sys(clk_sys), .srst(srst),
      .primary_mode_cfg(primary_mode_cfg), .initial_source_cfg(initial_source_cfg),
      .ext_clock_range_cfg(ext_clock_range_cfg), .switch_monitor_cfg(switch_monitor_cfg),
      .osc_pin_function_cfg(osc_pin_function_cfg), .pll_locked_in(pll_locked_in),
      .clock_fail_in(clock_fail_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active_source(active_source),
      .primary_kind(primary_kind), .primary_osc_en(primary_osc_en),
      .secondary_osc_en(secondary_osc_en), .fast_rc_en(fast_rc_en),
      .low_power_fast_rc_en(low_power_fast_rc_en), .low_power_rc_en(low_power_rc_en),
      .pll_en(pll_en), .postscaler_en(postscaler_en), .postscaler_sel(postscaler_sel),
      .ext_range(ext_range), .osc_pin_gpio(osc_pin_gpio), .fail_monitor_en(fail_monitor_en),
      .switch_busy(switch_busy), .doze_en(doze_en), .doze_ratio(doze_ratio),
      .doze_exit_on_irq(doze_exit_on_irq), .rc_tune(rc_tune));

   // ----------------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------------
   task end_of_test;
      if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Configuration changes under reset, as it would from non-volatile storage; t_switch sets the range one cycle before reset.
   task do_reset(input logic [1:0] pm, input logic [2:0] src, input logic [1:0] sm);
      @(posedge clk_sys);
      srst <= 1'b1;
      primary_mode_cfg <= pm;
      initial_source_cfg <= src;
      switch_monitor_cfg <= sm;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   task wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------------
   task t_boot;
      logic [4:0] cfgs [11];
      logic [15:0] d;
      logic [2:0] s;
      logic prim;
      cfgs = '{5'h1e, 5'h1d, 5'h04, 5'h13, 5'h03, 5'h12, 5'h0a, 5'h02, 5'h19, 5'h18, 5'h1f};
      for (int i = 0; i < 11; i++) begin
         s = cfgs[i][2:0];
         prim = (s == 3'h2 || s == 3'h3) && cfgs[i][4:3] != 2'h3;
         do_reset(cfgs[i][4:3], s, 2'h3);
         rd(2'h0, d);
         chk(d & 16'hffdf, {1'b0, s, 1'b0, s, 8'h00}, "boot control");
         chk(16'(active_source), 16'(s), "boot source");
         chk(16'(pll_en), 16'(s == 3'h3 || s == 3'h1), "pll use");
         chk(16'(postscaler_en), 16'(s inside {3'h7, 3'h6, 3'h1}), "postscaler");
         chk(16'(primary_osc_en), 16'(prim), "primary use");
         chk(16'(secondary_osc_en), 16'(s == 3'h4), "secondary use");
         chk(16'(osc_pin_gpio), 16'(!prim), "pin function");
         chk(16'(fast_rc_en), 16'(s inside {3'h7, 3'h1, 3'h0}), "fast rc use");
         chk(16'(low_power_fast_rc_en), 16'(s == 3'h6), "low power fast rc");
         chk(16'(low_power_rc_en), 16'(s == 3'h5), "low power rc");
         chk(16'(primary_kind), 16'(cfgs[i][4:3]), "primary kind");
      end
      chk(16'(active_source), 16'h7, "erased start");
      chk(16'(ext_range), 16'h3, "erased range");
      chk(16'(fail_monitor_en), 16'h0, "monitor off");
      rd(2'h1, d);
      chk(d, 16'h3000, "divider reset");
      chk(16'({doze_exit_on_irq, doze_ratio, doze_en, postscaler_sel}), 16'h0030, "div out");
      wr(2'h1, 16'hffff);
      rd(2'h1, d);
      chk(d, 16'hff00, "divider bits");
      chk(16'({doze_exit_on_irq, doze_ratio, doze_en, postscaler_sel}), 16'h00ff, "div set");
      wr(2'h2, 16'hffff);
      rd(2'h2, d);
      chk(d, 16'h003f, "tune bits");
      chk(16'(rc_tune), 16'h003f, "tune output");
      wr(2'h3, 16'hffff);
      rd(2'h3, d);
      chk(d, 16'h0000, "unmapped");
   endtask

   task t_switch;
      logic [15:0] d;
      int n;
      @(posedge clk_sys);
      ext_clock_range_cfg <= 2'h1;
      do_reset(2'h3, 3'h7, 2'h1);
      chk(16'(ext_range), 16'h1, "range");
      wr(2'h0, 16'h8901);
      rd(2'h0, d);
      chk(16'(d[5]), 16'h0, "lock in switch");
      chk(16'(switch_busy), 16'h1, "busy in switch");
      n = 0;
      while (active_source !== 3'h1 && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      repeat (12) @(posedge clk_sys);
      rd(2'h0, d);
      chk(d, 16'h1120, "after switch");
   endtask

   task t_disabled;
      logic [15:0] d;
      do_reset(2'h3, 3'h0, 2'h2);
      wr(2'h0, 16'h0701);
      repeat (30) @(posedge clk_sys);
      chk(16'(active_source), 16'h0, "no switch");
      rd(2'h0, d);
      chk(d, 16'h0700, "request refused");
   endtask

   task t_lock_fail;
      logic [15:0] d;
      do_reset(2'h3, 3'h7, 2'h0);
      chk(16'(fail_monitor_en), 16'h1, "monitor on");
      wr(2'h0, 16'h0680);
      wr(2'h0, 16'h0000);
      wr(2'h0, 16'h0089);
      repeat (10) @(posedge clk_sys);
      chk(16'(active_source), 16'h7, "locked source");
      rd(2'h0, d);
      chk(d, 16'h7680, "lock held, flag not set");
      fail_cmd <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd(2'h0, d);
      chk(d, 16'h7688, "failure flagged");
      wr(2'h0, 16'h0080);
      rd(2'h0, d);
      chk(d, 16'h7680, "flag cleared");
   endtask

   // ----------------------------------------------------------------------
   // Main sequence and watchdog.
   // ----------------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      t_boot();
      t_switch();
      t_disabled();
      t_lock_fail();
      end_of_test();
   end

   // The whole run needs well under a thousand cycles; this only cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_of_test();
   end
endmodule // testbench
